// >>> pll_loop_and_input_switch_control.sv
// loop bandwidth, feedback divider, input selection and holdover control bank behind an APB slave
// assumes one 20 MHz clock, inputs synchronous to it, and a loop core that consumes the live values
`timescale 1ns/10ps
`default_nettype none

module pll_loop_and_input_switch_control #(
	parameter int HIST_DEPTH = pll_ctrl_pkg::HIST_DEPTH_DEF
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// input clock state
	input  wire logic [1:0]  sel_pins,
	input  wire logic [3:0]  input_available,
	input  wire logic [11:0] input_priority,
	input  wire logic        loop_locked,
	input  wire logic [31:0] freq_sample,
	input  wire logic        freq_sample_valid,
	// loop control
	output var  logic [47:0] loop_bandwidth_out,
	output var  logic [55:0] feedback_numerator,
	output var  logic [31:0] feedback_denominator,
	output var  logic        quick_acquire_active,
	output var  logic        holdover_active,
	output var  logic [31:0] holdover_frequency,
	output var  logic        holdover_frequency_valid,
	output var  logic        holdover_ramp_bypass,
	// input switch control
	output var  logic [1:0]  active_input,
	output var  logic        feedback_clock_input_selected,
	output var  logic [1:0]  input_switch_policy,
	output var  logic        phase_buildout_enable,
	output var  logic        zero_delay_enable,
	output var  logic [1:0]  zero_delay_input
);

	localparam int PTR_W = $clog2(HIST_DEPTH);
	localparam int SUM_W = 38;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic byte_hit(input logic [13:0] idx, input logic [13:0] base, input int k);
		byte_hit = (idx == 14'(base + 14'(k)));
	endfunction

	function automatic logic usable(input logic avail, input logic [2:0] prio);
		usable = avail && (prio != pll_ctrl_pkg::PRIO_NONE) && (prio <= pll_ctrl_pkg::PRIO_LOWEST);
	endfunction

	// lowest level wins; strict compare keeps the lower-numbered input on a tie
	function automatic logic [2:0] auto_pick(input logic [3:0] avail, input logic [11:0] prio);
		logic       found;
		logic [1:0] best;
		logic [2:0] best_prio;
		found = 1'b0;
		best = 2'd0;
		best_prio = 3'd7;
		for (int i = 0; i < 4; i++) begin
			if (usable(avail[i], prio[3*i +: 3]) && (!found || prio[3*i +: 3] < best_prio)) begin
				found = 1'b1;
				best = 2'(i);
				best_prio = prio[3*i +: 3];
			end
		end
		auto_pick = {found, best};
	endfunction

	// ****************************************
	// apb decode
	// ****************************************
	logic [13:0] idx;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic        mapped;
	logic [7:0]  rd_byte;

	assign idx = paddr[15:2];
	assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;
	assign wbyte = pwdata[7:0];
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ****************************************
	// staged and live parameters
	// ****************************************
	logic [47:0] loop_bw_stage, fast_bw_stage, loop_bw_live, fast_bw_live;
	logic [55:0] num_stage;
	logic [31:0] den_stage;
	logic        bw_commit, fb_commit;

	assign bw_commit = wr_en && idx == pll_ctrl_pkg::IDX_BW_COMMIT && wbyte[pll_ctrl_pkg::COMMIT_BIT];
	assign fb_commit = wr_en && idx == pll_ctrl_pkg::IDX_FB_COMMIT && wbyte[pll_ctrl_pkg::COMMIT_BIT];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_bw_stage <= '0;
			fast_bw_stage <= '0;
			num_stage <= '0;
			den_stage <= '0;
		end else begin
			for (int k = 0; k < pll_ctrl_pkg::BW_BYTES; k++) begin
				if (wr_en && byte_hit(idx, pll_ctrl_pkg::IDX_LOOP_BW, k))
					loop_bw_stage[8*k +: 8] <= wbyte;
				if (wr_en && byte_hit(idx, pll_ctrl_pkg::IDX_FAST_BW, k))
					fast_bw_stage[8*k +: 8] <= wbyte;
			end
			for (int k = 0; k < pll_ctrl_pkg::NUM_BYTES; k++) begin
				if (wr_en && byte_hit(idx, pll_ctrl_pkg::IDX_FB_NUM, k))
					num_stage[8*k +: 8] <= wbyte;
			end
			for (int k = 0; k < pll_ctrl_pkg::DEN_BYTES; k++) begin
				if (wr_en && byte_hit(idx, pll_ctrl_pkg::IDX_FB_DEN, k))
					den_stage[8*k +: 8] <= wbyte;
			end
		end
	end

	// the commit bits are strobes with no storage, so they always read back zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_bw_live <= '0;
			fast_bw_live <= '0;
		end else if (bw_commit) begin
			loop_bw_live <= loop_bw_stage;
			fast_bw_live <= fast_bw_stage;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			feedback_numerator <= '0;
			feedback_denominator <= '0;
		end else if (fb_commit) begin
			feedback_numerator <= num_stage;
			feedback_denominator <= den_stage;
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	logic       sel_from_reg;
	logic [1:0] sel_field;
	logic       auto_qa_off;
	logic       force_qa;
	logic       exit_use_normal;
	logic [4:0] hist_len;
	logic [4:0] hist_delay;
	logic       force_hold;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zero_delay_enable <= 1'b0;
			zero_delay_input <= 2'd0;
			sel_from_reg <= 1'b0;
			sel_field <= 2'd0;
			auto_qa_off <= 1'b0;
			force_qa <= 1'b0;
			holdover_ramp_bypass <= 1'b0;
			exit_use_normal <= 1'b0;
			hist_len <= 5'd0;
			hist_delay <= 5'd0;
			force_hold <= 1'b0;
			input_switch_policy <= pll_ctrl_pkg::POLICY_MANUAL;
			phase_buildout_enable <= 1'b0;
		end else if (wr_en) begin
			case (idx)
				pll_ctrl_pkg::IDX_ZERO_DELAY: begin
					zero_delay_enable <= wbyte[pll_ctrl_pkg::ZD_EN_BIT];
					zero_delay_input <= wbyte[pll_ctrl_pkg::ZD_SEL_LSB +: 2];
				end
				pll_ctrl_pkg::IDX_INPUT_CHOICE: begin
					sel_from_reg <= wbyte[pll_ctrl_pkg::SRC_BIT];
					sel_field <= wbyte[pll_ctrl_pkg::SEL_LSB +: 2];
				end
				pll_ctrl_pkg::IDX_QUICK_ACQ: begin
					auto_qa_off <= wbyte[pll_ctrl_pkg::AUTO_OFF_BIT];
					force_qa <= wbyte[pll_ctrl_pkg::FORCE_QA_BIT];
				end
				pll_ctrl_pkg::IDX_HOLD_EXIT: begin
					holdover_ramp_bypass <= wbyte[pll_ctrl_pkg::RAMP_BIT];
					exit_use_normal <= wbyte[pll_ctrl_pkg::EXIT_BIT];
				end
				pll_ctrl_pkg::IDX_HOLD_LEN:   hist_len <= wbyte[pll_ctrl_pkg::HIST_MSB:0];
				pll_ctrl_pkg::IDX_HOLD_DELAY: hist_delay <= wbyte[pll_ctrl_pkg::HIST_MSB:0];
				pll_ctrl_pkg::IDX_HOLD_FORCE: force_hold <= wbyte[pll_ctrl_pkg::FORCE_HOLD_BIT];
				pll_ctrl_pkg::IDX_SWITCH: begin
					if (wbyte[pll_ctrl_pkg::POLICY_LSB +: 2] != pll_ctrl_pkg::POLICY_RESERVED)
						input_switch_policy <= wbyte[pll_ctrl_pkg::POLICY_LSB +: 2];
					phase_buildout_enable <= wbyte[pll_ctrl_pkg::BUILDOUT_BIT];
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// input selection
	// ****************************************
	logic [1:0] manual_code;
	logic [2:0] auto_choice;
	logic       auto_mode;
	logic       current_ok;
	logic       next_hold;
	logic [1:0] next_input;

	// zero-delay mode allows neither automatic nor register selection
	assign manual_code = (sel_from_reg && !zero_delay_enable) ? sel_field : sel_pins;
	assign auto_mode = (input_switch_policy != pll_ctrl_pkg::POLICY_MANUAL) && !zero_delay_enable;
	assign auto_choice = auto_pick(input_available, input_priority);
	assign current_ok = usable(input_available[active_input], input_priority[3*active_input +: 3]);

	always_comb begin
		next_input = active_input;
		next_hold = force_hold;
		if (!auto_mode) begin
			next_input = manual_code;
			next_hold = next_hold || !input_available[manual_code];
		end else if (!auto_choice[2]) begin
			next_hold = 1'b1;
		end else if (input_switch_policy == pll_ctrl_pkg::POLICY_AUTO_REV || !current_ok) begin
			next_input = auto_choice[1:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			active_input <= 2'd0;
			feedback_clock_input_selected <= 1'b0;
			holdover_active <= 1'b0;
		end else begin
			active_input <= next_input;
			// code 3 names the feedback input once zero-delay mode is on
			feedback_clock_input_selected <= zero_delay_enable && next_input == 2'd3;
			holdover_active <= next_hold;
		end
	end

	// ****************************************
	// quick acquire and bandwidth choice
	// ****************************************
	logic hold_prev;
	logic exit_fast_pending;
	logic next_qa;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_prev <= 1'b0;
			exit_fast_pending <= 1'b0;
		end else begin
			hold_prev <= holdover_active;
			// leaving holdover wins over a lock seen in the same cycle
			if (hold_prev && !holdover_active && !exit_use_normal)
				exit_fast_pending <= 1'b1;
			else if (loop_locked || holdover_active)
				exit_fast_pending <= 1'b0;
		end
	end

	assign next_qa = force_qa || (!auto_qa_off && !loop_locked) || exit_fast_pending;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			quick_acquire_active <= 1'b0;
			loop_bandwidth_out <= '0;
		end else begin
			quick_acquire_active <= next_qa;
			loop_bandwidth_out <= next_qa ? fast_bw_live : loop_bw_live;
		end
	end

	// ****************************************
	// holdover history and averaging
	// ****************************************
	// history is frozen during holdover so the average never sees holdover samples
	logic [31:0]      hist_mem [HIST_DEPTH];
	logic [PTR_W-1:0] wr_ptr, rd_ptr;
	pll_ctrl_pkg::avg_state_e avg_state;
	logic [SUM_W-1:0] avg_sum;
	logic [5:0]       avg_left;
	logic [5:0]       avg_count;
	logic [6:0]       rem;
	logic [6:0]       trial;

	always_ff @(posedge clk) begin
		if (freq_sample_valid && !holdover_active)
			hist_mem[wr_ptr] <= freq_sample;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wr_ptr <= '0;
		else if (freq_sample_valid && !holdover_active)
			wr_ptr <= PTR_W'(wr_ptr + PTR_W'(1));
	end

	assign trial = {rem[5:0], avg_sum[SUM_W-1]};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avg_state <= pll_ctrl_pkg::AVG_IDLE;
			rd_ptr <= '0;
			avg_sum <= '0;
			avg_left <= 6'd0;
			avg_count <= 6'd0;
			rem <= 7'd0;
			holdover_frequency <= '0;
			holdover_frequency_valid <= 1'b0;
		end else begin
			case (avg_state)
				pll_ctrl_pkg::AVG_IDLE: begin
					if (holdover_active && !hold_prev) begin
						// newest sample sits at wr_ptr-1; skip back by the delay first
						rd_ptr <= PTR_W'(wr_ptr - PTR_W'(1) - PTR_W'(hist_delay));
						avg_count <= 6'({1'b0, hist_len} + 6'd1);
						avg_left <= 6'({1'b0, hist_len} + 6'd1);
						avg_sum <= '0;
						avg_state <= pll_ctrl_pkg::AVG_SUM;
					end
					if (!holdover_active)
						holdover_frequency_valid <= 1'b0;
				end
				pll_ctrl_pkg::AVG_SUM: begin
					avg_sum <= SUM_W'(avg_sum + {6'd0, hist_mem[rd_ptr]});
					rd_ptr <= PTR_W'(rd_ptr - PTR_W'(1));
					avg_left <= 6'(avg_left - 6'd1);
					if (avg_left == 6'd1) begin
						rem <= 7'd0;
						avg_left <= 6'(SUM_W);
						avg_state <= pll_ctrl_pkg::AVG_DIV;
					end
				end
				pll_ctrl_pkg::AVG_DIV: begin
					// restoring division, one quotient bit per cycle
					if (trial >= {1'b0, avg_count}) begin
						rem <= 7'(trial - {1'b0, avg_count});
						avg_sum <= {avg_sum[SUM_W-2:0], 1'b1};
					end else begin
						rem <= trial;
						avg_sum <= {avg_sum[SUM_W-2:0], 1'b0};
					end
					avg_left <= 6'(avg_left - 6'd1);
					if (avg_left == 6'd0) begin
						holdover_frequency <= avg_sum[31:0];
						holdover_frequency_valid <= holdover_active;
						avg_state <= pll_ctrl_pkg::AVG_IDLE;
					end
				end
				default: avg_state <= pll_ctrl_pkg::AVG_IDLE;
			endcase
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		rd_byte = 8'h00;
		mapped = (paddr[1:0] == 2'd0);
		case (idx)
			pll_ctrl_pkg::IDX_ZERO_DELAY:   rd_byte = {5'd0, zero_delay_input, zero_delay_enable};
			pll_ctrl_pkg::IDX_ACTIVE_INPUT: rd_byte = {active_input, 6'd0};
			pll_ctrl_pkg::IDX_BW_COMMIT:    rd_byte = 8'h00;
			pll_ctrl_pkg::IDX_FB_COMMIT:    rd_byte = 8'h00;
			pll_ctrl_pkg::IDX_INPUT_CHOICE: rd_byte = {5'd0, sel_field, sel_from_reg};
			pll_ctrl_pkg::IDX_QUICK_ACQ:    rd_byte = {6'd0, force_qa, auto_qa_off};
			pll_ctrl_pkg::IDX_HOLD_EXIT:    rd_byte = {3'd0, exit_use_normal, holdover_ramp_bypass, 3'd0};
			pll_ctrl_pkg::IDX_HOLD_LEN:     rd_byte = {3'd0, hist_len};
			pll_ctrl_pkg::IDX_HOLD_DELAY:   rd_byte = {3'd0, hist_delay};
			pll_ctrl_pkg::IDX_HOLD_FORCE:   rd_byte = {7'd0, force_hold};
			pll_ctrl_pkg::IDX_SWITCH:       rd_byte = {5'd0, phase_buildout_enable, input_switch_policy};
			pll_ctrl_pkg::IDX_STATUS:
				rd_byte = {4'd0, feedback_clock_input_selected, avg_state != pll_ctrl_pkg::AVG_IDLE,
					quick_acquire_active, holdover_active};
			default: begin
				mapped = 1'b0;
				for (int k = 0; k < pll_ctrl_pkg::BW_BYTES; k++) begin
					if (byte_hit(idx, pll_ctrl_pkg::IDX_LOOP_BW, k)) begin
						rd_byte = loop_bw_stage[8*k +: 8];
						mapped = 1'b1;
					end
					if (byte_hit(idx, pll_ctrl_pkg::IDX_FAST_BW, k)) begin
						rd_byte = fast_bw_stage[8*k +: 8];
						mapped = 1'b1;
					end
				end
				for (int k = 0; k < pll_ctrl_pkg::NUM_BYTES; k++) begin
					if (byte_hit(idx, pll_ctrl_pkg::IDX_FB_NUM, k)) begin
						rd_byte = num_stage[8*k +: 8];
						mapped = 1'b1;
					end
				end
				for (int k = 0; k < pll_ctrl_pkg::DEN_BYTES; k++) begin
					if (byte_hit(idx, pll_ctrl_pkg::IDX_FB_DEN, k)) begin
						rd_byte = den_stage[8*k +: 8];
						mapped = 1'b1;
					end
					if (byte_hit(idx, pll_ctrl_pkg::IDX_HOLD_FREQ, k)) begin
						rd_byte = holdover_frequency[8*k +: 8];
						mapped = 1'b1;
					end
				end
				mapped = mapped && (paddr[1:0] == 2'd0);
			end
		endcase
	end

	// read data is captured in the setup cycle so it stands through the access cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			prdata <= '0;
		else if (psel && !penable)
			prdata <= {24'h00_0000, rd_byte};
	end

endmodule

`default_nettype wire

// >>> pll_ctrl_pkg.sv
// register indices, field positions, reset values and enumerations for the loop control bank
// assumes byte-wide registers, each one placed on its own aligned 32-bit word (byte address = 4 x index)
package pll_ctrl_pkg;

	// ****************************************
	// register indices
	// ****************************************
	localparam logic [13:0] IDX_ZERO_DELAY   = 14'h0487;
	localparam logic [13:0] IDX_ACTIVE_INPUT = 14'h0507;
	localparam logic [13:0] IDX_LOOP_BW      = 14'h0508;
	localparam logic [13:0] IDX_FAST_BW      = 14'h050E;
	localparam logic [13:0] IDX_BW_COMMIT    = 14'h0514;
	localparam logic [13:0] IDX_FB_NUM       = 14'h0515;
	localparam logic [13:0] IDX_FB_DEN       = 14'h051C;
	localparam logic [13:0] IDX_FB_COMMIT    = 14'h0520;
	localparam logic [13:0] IDX_INPUT_CHOICE = 14'h052A;
	localparam logic [13:0] IDX_QUICK_ACQ    = 14'h052B;
	localparam logic [13:0] IDX_HOLD_EXIT    = 14'h052C;
	localparam logic [13:0] IDX_HOLD_LEN     = 14'h052E;
	localparam logic [13:0] IDX_HOLD_DELAY   = 14'h052F;
	localparam logic [13:0] IDX_HOLD_FORCE   = 14'h0535;
	localparam logic [13:0] IDX_SWITCH       = 14'h0536;
	localparam logic [13:0] IDX_STATUS       = 14'h053A;
	localparam logic [13:0] IDX_HOLD_FREQ    = 14'h053B;

	// ****************************************
	// multi-byte group sizes
	// ****************************************
	localparam int BW_BYTES   = 6;
	localparam int NUM_BYTES  = 7;
	localparam int DEN_BYTES  = 4;
	localparam int FREQ_BYTES = 4;

	// ****************************************
	// field positions
	// ****************************************
	localparam int COMMIT_BIT     = 0;
	localparam int ZD_EN_BIT      = 0;
	localparam int ZD_SEL_LSB     = 1;
	localparam int SRC_BIT        = 0;
	localparam int SEL_LSB        = 1;
	localparam int AUTO_OFF_BIT   = 0;
	localparam int FORCE_QA_BIT   = 1;
	localparam int RAMP_BIT       = 3;
	localparam int EXIT_BIT       = 4;
	localparam int HIST_MSB       = 4;
	localparam int FORCE_HOLD_BIT = 0;
	localparam int POLICY_LSB     = 0;
	localparam int BUILDOUT_BIT   = 2;
	localparam int ACTIVE_LSB     = 6;
	localparam int ST_HOLD_BIT    = 0;
	localparam int ST_QA_BIT      = 1;
	localparam int ST_AVG_BIT     = 2;
	localparam int ST_FB_BIT      = 3;

	// ****************************************
	// reset values and limits
	// ****************************************
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [2:0] PRIO_NONE      = 3'h0;
	localparam logic [2:0] PRIO_LOWEST    = 3'h4;
	localparam int         HIST_DEPTH_DEF = 64;

	typedef enum logic [1:0] {
		POLICY_MANUAL,
		POLICY_AUTO_NONREV,
		POLICY_AUTO_REV,
		POLICY_RESERVED
	} switch_policy_e;

	typedef enum logic [1:0] {
		AVG_IDLE,
		AVG_SUM,
		AVG_DIV
	} avg_state_e;

endpackage

// >>> pll_ctrl_properties.sv
// concurrent checks on the loop control bank, seen from its ports only
// assumes the apb byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none

module pll_ctrl_properties (
	// clock and reset
	input wire logic        clk,
	input wire logic        arst_n,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	// control outputs
	input wire logic        quick_acquire_active,
	input wire logic        holdover_active,
	input wire logic        holdover_ramp_bypass,
	input wire logic [1:0]  input_switch_policy,
	input wire logic        phase_buildout_enable,
	input wire logic        zero_delay_enable
);
	localparam logic [15:0] A_SW = {pll_ctrl_pkg::IDX_SWITCH, 2'b00};
	localparam logic [15:0] A_ZD = {pll_ctrl_pkg::IDX_ZERO_DELAY, 2'b00};
	localparam logic [15:0] A_HX = {pll_ctrl_pkg::IDX_HOLD_EXIT, 2'b00};
	localparam logic [15:0] A_HF = {pll_ctrl_pkg::IDX_HOLD_FORCE, 2'b00};
	localparam logic [15:0] A_QA = {pll_ctrl_pkg::IDX_QUICK_ACQ, 2'b00};
	localparam logic [15:0] A_BC = {pll_ctrl_pkg::IDX_BW_COMMIT, 2'b00};
	logic wr;

	// a write lands only with the low byte strobe set
	assign wr = psel && penable && pwrite && pstrb[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	// **********
	// properties
	// **********
	chk_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	chk_policy_write: assert property (wr && paddr == A_SW && pwdata[1:0] != 2'h3
		|=> input_switch_policy == $past(pwdata[1:0])) else $error("policy not taken");
	chk_reserved_kept: assert property (wr && paddr == A_SW && pwdata[1:0] == 2'h3
		|=> $stable(input_switch_policy)) else $error("reserved policy changed mode");
	chk_buildout_write: assert property (wr && paddr == A_SW
		|=> phase_buildout_enable == $past(pwdata[2])) else $error("build-out bit wrong");
	chk_zero_delay_bit: assert property (wr && paddr == A_ZD
		|=> zero_delay_enable == $past(pwdata[0])) else $error("zero-delay bit wrong");
	chk_ramp_bypass_bit: assert property (wr && paddr == A_HX
		|=> holdover_ramp_bypass == $past(pwdata[3])) else $error("ramp bypass bit wrong");
	chk_force_hold: assert property (wr && paddr == A_HF && pwdata[0]
		|-> ##[1:3] holdover_active) else $error("forced holdover not entered");
	chk_force_quick: assert property (wr && paddr == A_QA && pwdata[1]
		|-> ##[1:3] quick_acquire_active) else $error("forced quick acquire missing");
	chk_commit_reads_zero: assert property (psel && penable && !pwrite && paddr == A_BC
		|-> prdata == 32'h0000_0000) else $error("commit strobe reads nonzero");
endmodule

bind pll_loop_and_input_switch_control pll_ctrl_properties pll_ctrl_properties_i (.*);

`default_nettype wire

// >>> pll_loop_and_input_switch_control_bench.sv
// self-checking bench for the loop control bank, driven over apb
// assumes the checker file is compiled with it and binds itself
`timescale 1ns/10ps
`default_nettype none

module pll_loop_and_input_switch_control_bench;
	// **********
	// signals
	// **********
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, loop_locked, freq_sample_valid;
	logic quick_acquire_active, holdover_active, holdover_frequency_valid, holdover_ramp_bypass;
	logic feedback_clock_input_selected, phase_buildout_enable, zero_delay_enable, err;
	logic [1:0] sel_pins, active_input, input_switch_policy, zero_delay_input;
	logic [3:0] pstrb, input_available;
	logic [11:0] input_priority;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, freq_sample, holdover_frequency, feedback_denominator, q;
	logic [47:0] loop_bandwidth_out;
	logic [55:0] feedback_numerator;
	int fail_count, cmp_count, cycles;
	localparam logic [47:0] BW_N = 48'h1234_5678_9abc;
	localparam logic [47:0] BW_F = 48'h0f1e_2d3c_4b5a;
	localparam logic [55:0] NUM = 56'h11_2233_4455_6677;
	localparam logic [31:0] DEN = 32'h89ab_cdef;

	pll_loop_and_input_switch_control pll_loop_and_input_switch_control_i (.*);

	always #25 clk = ~clk;

	// **********
	// tasks
	// **********
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// one full transfer, then an idle edge so strobes never toggle twice in a step
	task automatic apb(input logic [13:0] idx, input logic w, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		// no fixed wait count: only the bench timeout ends a stalled access
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wrn(input logic [13:0] idx, input int n, input logic [63:0] v);
		for (int i = 0; i < n; i++) apb(14'(idx + i), 1'b1, v[8*i+:8]);
	endtask
	task automatic rdn(input logic [13:0] idx, input int n, input logic [63:0] v);
		for (int i = 0; i < n; i++) begin
			apb(14'(idx + i), 1'b0, 8'h00);
			chk("byte", v[8*i+:8], q);
		end
	endtask
	task automatic sample(input logic [31:0] v);
		freq_sample <= v;
		freq_sample_valid <= 1'b1;
		@(posedge clk);
		freq_sample_valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ceiling far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			finish_test();
		end
	end

	// **********
	// sequence
	// **********
	initial begin
		clk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		pstrb = 4'hf; sel_pins = 2'h2; input_available = 4'hf; input_priority = 12'h000;
		loop_locked = 1; freq_sample = 0; freq_sample_valid = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		wrn(pll_ctrl_pkg::IDX_LOOP_BW, 6, BW_N);
		wrn(pll_ctrl_pkg::IDX_FAST_BW, 6, BW_F);
		rdn(pll_ctrl_pkg::IDX_LOOP_BW, 6, BW_N);
		rdn(pll_ctrl_pkg::IDX_FAST_BW, 6, BW_F);
		chk("bw staged", 0, loop_bandwidth_out);
		apb(pll_ctrl_pkg::IDX_BW_COMMIT, 1, 8'h01);
		repeat (3) @(posedge clk);
		chk("bw live", BW_N, loop_bandwidth_out);
		apb(pll_ctrl_pkg::IDX_BW_COMMIT, 0, 8'h00);
		chk("commit read", 0, q);
		apb(pll_ctrl_pkg::IDX_QUICK_ACQ, 1, 8'h02);
		repeat (3) @(posedge clk);
		chk("bw fast", BW_F, loop_bandwidth_out);
		apb(pll_ctrl_pkg::IDX_QUICK_ACQ, 1, 8'h00);
		loop_locked <= 1'b0;
		repeat (3) @(posedge clk);
		chk("auto on", 1, quick_acquire_active);
		apb(pll_ctrl_pkg::IDX_QUICK_ACQ, 1, 8'h01);
		repeat (3) @(posedge clk);
		chk("auto off", 0, quick_acquire_active);
		wrn(pll_ctrl_pkg::IDX_FB_NUM, 7, NUM);
		wrn(pll_ctrl_pkg::IDX_FB_DEN, 4, DEN);
		chk("num staged", 0, feedback_numerator);
		apb(pll_ctrl_pkg::IDX_FB_COMMIT, 1, 8'h01);
		repeat (3) @(posedge clk);
		chk("num", NUM, feedback_numerator);
		chk("den", DEN, feedback_denominator);
		apb(pll_ctrl_pkg::IDX_INPUT_CHOICE, 1, 8'h02);
		repeat (3) @(posedge clk);
		chk("pin select", 2, active_input);
		for (int c = 0; c < 4; c++) begin
			apb(pll_ctrl_pkg::IDX_INPUT_CHOICE, 1, 8'(2 * c + 1));
			repeat (3) @(posedge clk);
			chk("reg select", c, active_input);
		end
		apb(pll_ctrl_pkg::IDX_ZERO_DELAY, 1, 8'h03);
		repeat (3) @(posedge clk);
		chk("zd pins", 2, active_input);
		chk("zd input", 1, zero_delay_input);
		chk("fb sel off", 0, feedback_clock_input_selected);
		sel_pins <= 2'h3;
		repeat (3) @(posedge clk);
		chk("fb sel on", 1, feedback_clock_input_selected);
		apb(pll_ctrl_pkg::IDX_ZERO_DELAY, 1, 8'h00);
		// priorities set first so the automatic modes never fall into holdover here
		input_priority <= {3'h2, 3'h1, 3'h1, 3'h3};
		for (int p = 0; p < 4; p++) begin
			apb(pll_ctrl_pkg::IDX_SWITCH, 1, 8'(p + 4));
			chk("policy", (p == 3) ? 2 : p, input_switch_policy);
			chk("buildout", 1, phase_buildout_enable);
		end
		repeat (3) @(posedge clk);
		chk("prio tie", 1, active_input);
		input_available <= 4'b1101;
		repeat (3) @(posedge clk);
		chk("prio next", 2, active_input);
		input_available <= 4'hf;
		apb(pll_ctrl_pkg::IDX_SWITCH, 1, 8'h00);
		apb(pll_ctrl_pkg::IDX_HOLD_LEN, 1, 8'h01);
		apb(pll_ctrl_pkg::IDX_HOLD_DELAY, 1, 8'h01);
		sample(32'h0000_0064);
		sample(32'h0000_00c8);
		sample(32'h0000_012c);
		apb(pll_ctrl_pkg::IDX_HOLD_EXIT, 1, 8'h08);
		apb(pll_ctrl_pkg::IDX_HOLD_FORCE, 1, 8'h01);
		for (int i = 0; i < 200 && holdover_frequency_valid !== 1'b1; i++) @(posedge clk);
		chk("hold", 1, holdover_active);
		chk("hold valid", 1, holdover_frequency_valid);
		chk("hold freq", 32'h0000_0096, holdover_frequency);
		apb(pll_ctrl_pkg::IDX_HOLD_FORCE, 1, 8'h00);
		repeat (3) @(posedge clk);
		chk("exit fast", 1, quick_acquire_active);
		loop_locked <= 1'b1;
		repeat (3) @(posedge clk);
		chk("locked", 0, quick_acquire_active);
		apb(14'h0600, 0, 8'h00);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, q);
		finish_test();
	end
endmodule

`default_nettype wire
